//--- verilog/bcs_pkg.sv
// Purpose: shared constants for the commutation sequencer
// Assumes: 10 MHz system clock
// Notes:   bit 0 of a drive pattern is output one
package bcs_pkg;

    // ==========================================
    // timing
    localparam int unsigned CLK_HZ        = 10_000_000;
    localparam int unsigned CHOP_FREQ_HZ  = 30_000;
    localparam int unsigned CHOP_CYC      = CLK_HZ / CHOP_FREQ_HZ;
    localparam int unsigned TACH_PULSE_NS = 10_000;
    localparam int unsigned TACH_CYC      = (TACH_PULSE_NS * (CLK_HZ / 1_000_000)) / 1_000;

    // ==========================================
    // register offsets
    localparam logic [3:0] REG_CTRL   = 4'h0;
    localparam logic [3:0] REG_DUTY   = 4'h1;
    localparam logic [3:0] REG_STATUS = 4'h2;

    // ==========================================
    // control fields
    localparam int CTRL_RUN   = 0;
    localparam int CTRL_FWD   = 1;
    localparam int CTRL_CS    = 2;
    localparam int CTRL_LATCH = 4;
    localparam int CTRL_FOUR  = 5;
    localparam int CTRL_TACH  = 6;
    localparam logic [7:0]  CTRL_RESET = 8'h02;
    localparam logic [15:0] DUTY_RESET = 16'h0000;

    // ==========================================
    // status fields
    localparam int STAT_HALL = 0;
    localparam int STAT_OC   = 3;
    localparam int STAT_BRK  = 4;
    localparam int STAT_EN   = 5;
    localparam int STAT_DRV  = 6;

    // ==========================================
    // drive patterns
    localparam logic [5:0] DRV_OFF   = 6'h07;
    localparam logic [5:0] DRV_BRAKE = 6'h3f;

    // sensor spacing selected by the code select pair
    typedef enum logic [1:0] {
        SPC_60, SPC_120, SPC_240, SPC_300
    } bcs_spacing_t;

endpackage

//--- verilog/bcs_dec_if.sv
// Purpose: carries hall state to the decoder and drive pattern back from it
// Assumes: one clock domain
// Notes:   pattern is registered inside the decoder
`timescale 1ns/1ps
interface bcs_dec_if;
    logic [2:0] hall;
    logic [1:0] cs;
    logic       fwd;
    logic       four;
    logic [5:0] pattern;

    modport ctl (output hall, output cs, output fwd, output four, input pattern);
    modport dec (input hall, input cs, input fwd, input four, output pattern);
endinterface

//--- verilog/bcs_decode.sv
// Purpose: hall code to six driver pattern decoder
// Assumes: hall inputs already synchronised
// Notes:   sinking outputs 1..3 active low, sourcing 4..6 active high
`timescale 1ns/1ps
module bcs_decode
(
    // clock and reset
    input wire logic clk_sys_in,
    input wire logic rst_n_in,
    // decoder link
    bcs_dec_if.dec   dec
);

    typedef struct packed {
        logic [5:0] pat;
    } bcs_dec_state_t;

    bcs_dec_state_t st_q;
    bcs_dec_state_t st_d;

    // ==========================================
    // hall code to step 0..5, 7 when invalid
    function automatic logic [2:0] bcs_step(input logic [2:0] h, input logic [1:0] cs);
        logic [2:0] s;
        s = 3'h7;
        case (cs)
            2'h0, 2'h3:
                case (h)
                    3'h1: s = 3'h0;
                    3'h3: s = 3'h1;
                    3'h7: s = 3'h2;
                    3'h6: s = 3'h3;
                    3'h4: s = 3'h4;
                    3'h0: s = 3'h5;
                    default: s = 3'h7;
                endcase
            default:
                case (h)
                    3'h1: s = 3'h0;
                    3'h3: s = 3'h1;
                    3'h2: s = 3'h2;
                    3'h6: s = 3'h3;
                    3'h4: s = 3'h4;
                    3'h5: s = 3'h5;
                    default: s = 3'h7;
                endcase
        endcase
        // wider spacings run the same steps in the other direction
        if (s != 3'h7 && cs[1])
            s = 3'h5 - s;
        return s;
    endfunction

    // ==========================================
    // sink leg and source leg for a step
    function automatic logic [5:0] bcs_pair(input logic [2:0] s, input logic fwd);
        logic [1:0] snk;
        logic [1:0] src;
        logic [1:0] t;
        logic [5:0] p;
        snk = 2'h0;
        src = 2'h0;
        case (s)
            3'h0: begin snk = 2'h2; src = 2'h1; end // RULE7
            3'h1: begin snk = 2'h2; src = 2'h0; end // RULE8
            3'h2: begin snk = 2'h1; src = 2'h0; end
            3'h3: begin snk = 2'h1; src = 2'h2; end
            3'h4: begin snk = 2'h0; src = 2'h2; end
            3'h5: begin snk = 2'h0; src = 2'h1; end
            default: begin snk = 2'h3; src = 2'h3; end
        endcase
        if (!fwd)
        begin
            t   = snk;
            snk = src;
            src = t;
        end
        p = bcs_pkg::DRV_OFF;
        if (snk != 2'h3)
        begin
            p[snk]          = 1'b0; // RULE10
            p[3 + 32'(src)] = 1'b1; // RULE10
        end
        return p;
    endfunction

    // ==========================================
    // four phase: one output at a time
    function automatic logic [5:0] bcs_four(input logic [1:0] h, input logic fwd);
        logic [5:0] p;
        p = bcs_pkg::DRV_OFF;
        case ({h, fwd})
            3'b001, 3'b110: p[0] = 1'b0; // RULE12
            3'b101, 3'b010: p[2] = 1'b0; // RULE13
            3'b111, 3'b000: p[3] = 1'b1; // RULE12
            3'b011, 3'b100: p[5] = 1'b1; // RULE13
            default: p = bcs_pkg::DRV_OFF;
        endcase
        return p;
    endfunction

    // pattern depends only on hall and the control bits, so it repeats each turn
    always_comb
    begin
        st_d = st_q;
        if (dec.four)
            st_d.pat = bcs_four({dec.hall[0], dec.hall[1]}, dec.fwd); // sensor one, then two
        else
            st_d.pat = bcs_pair(bcs_step(dec.hall, dec.cs), dec.fwd); // RULE9 RULE18
    end

    // state register
    always_ff @(posedge clk_sys_in)
    begin
        if (!rst_n_in)
            st_q.pat <= bcs_pkg::DRV_OFF;
        else
            st_q <= st_d;
    end

    assign dec.pattern = st_q.pat;

endmodule

//--- verilog/bcs_sequencer.sv
// Purpose: brushless motor commutation sequencer with chopping
// Assumes: 10 MHz clock, sensor pins asynchronous to it
// Notes:   drive pins: bits 0..2 sink (low on), bits 3..5 source
//
// What this block does
// RULE1 - latched mode: trip clears enable flip-flop
// RULE2 - latched mode: re-enable on next saw edge
// RULE3 - plain mode: comparator gates drivers without storage
// RULE4 - overcurrent: sinks high, sources low
// RULE5 - brake beats overcurrent on every output
// RULE6 - brake: sinks off, all sources on
// RULE7 - 60 forward, hall 100: outputs 3,5
// RULE8 - 60 forward, hall 110: outputs 3,4
// RULE9 - hall sequence repeats each electrical turn
// RULE10 - one sink and one source per step
// RULE11 - four phase: selects low, hall 2,3 tied
// RULE12 - four phase table, one output each
// RULE13 - four phase hall 01: output 6/3
// RULE14 - single ended uses outputs 1,3,4,6
// RULE15 - feedback XORs hall inputs before detector
// RULE16 - falling edge gives fixed width pulse
// RULE17 - pin inputs synchronised before use
// RULE18 - code select picks spacing table
// RULE19 - sawtooth comparator chops outputs, full range
`timescale 1ns/1ps
module bcs_sequencer
#(
    parameter int unsigned CHOP_CYC = bcs_pkg::CHOP_CYC,
    parameter int unsigned TACH_CYC = bcs_pkg::TACH_CYC
)
(
    // clock and reset
    input  wire logic        clk_sys_in,
    input  wire logic        rst_n_in,

    // register port
    input  wire logic [3:0]  reg_addr_in,
    input  wire logic [15:0] reg_wdata_in,
    input  wire logic        reg_wr_in,
    input  wire logic        reg_rd_in,
    output logic      [15:0] reg_rdata_out,

    // motor pins
    input  wire logic [2:0]  hall_in,
    input  wire logic        overcurrent_in,
    input  wire logic        brake_in,

    // driver stage
    output logic      [5:0]  drv_out,

    // speed feedback
    output logic             tach_pulse_out
);

    // ==========================================
    // overview
    // pins pass two sync stages, then the decoder
    // and the gating, then one output register;
    // every output comes straight from a flip-flop
    // brake pattern 6'h3f: sinks off, sources on
    // off pattern 6'h07: sinks off, sources off
    // priority: brake, overcurrent, latched enable,
    // run and chop, then the hall pattern
    // brake and overcurrent reach drv_out after
    // three edges, a hall change after four, a
    // chop change after one
    // in latched mode the drive stays off for up
    // to one saw period after a trip has ended
    // tach_pulse_out marks each falling edge of
    // the chosen feedback level

    // ==========================================
    // state
    typedef struct packed {
        // pin synchroniser
        logic [4:0]  s1;      // first sync stage
        logic [4:0]  s2;      // second sync stage
        // speed feedback
        logic        fb_q;    // last feedback level
        logic [15:0] tach;    // feedback pulse timer
        logic        tpulse;
        // software registers
        logic [7:0]  ctrl;
        logic [15:0] duty;    // duty_threshold
        // chopping and drive
        logic [15:0] saw;     // sawtooth ramp
        logic        en;      // overcurrent enable flip-flop
        logic [5:0]  drv;
        // read data register
        logic [15:0] rdata;
    } bcs_state_t;

    bcs_state_t st_q;
    bcs_state_t st_d;

    // link to the hall decoder; its pattern is
    // registered, so a hall change reaches drv_out
    // one edge later than a brake or trip does
    // the modport keeps each signal's direction
    bcs_dec_if dif ();

    // ==========================================
    // decoder
    // hall pattern from the synced sensors
    bcs_decode u_dec
    (
        .clk_sys_in (clk_sys_in),
        .rst_n_in   (rst_n_in),
        .dec        (dif)
    );

    // ==========================================
    // synchronised views
    // every motor pin is asynchronous to the clock, so it
    // passes two flip-flops before any logic sees it;
    // only the second stage is read, the first one
    // feeds nothing but the second
    // a pulse shorter than one clock may be missed
    logic [2:0] hall_s;
    logic       oc_s;
    logic       brk_s;

    assign hall_s = st_q.s2[2:0];
    assign oc_s   = st_q.s2[3];
    assign brk_s  = st_q.s2[4];

    // control fields
    // run gates the pattern, brake works without it
    // fwd clear swaps the sink and source legs
    // latch picks the stored enable mode
    // four picks the one output at a time table
    // tsel picks the sensors of the feedback level
    logic       run;
    logic       fwd;
    logic [1:0] cs;
    logic       latch;
    logic       four;
    logic [1:0] tsel;

    assign run   = st_q.ctrl[bcs_pkg::CTRL_RUN];
    assign fwd   = st_q.ctrl[bcs_pkg::CTRL_FWD];
    assign cs    = st_q.ctrl[bcs_pkg::CTRL_CS +: 2];
    assign latch = st_q.ctrl[bcs_pkg::CTRL_LATCH];
    assign four  = st_q.ctrl[bcs_pkg::CTRL_FOUR];
    assign tsel  = st_q.ctrl[bcs_pkg::CTRL_TACH +: 2];

    // decoder inputs
    // synced hall and live control bits
    assign dif.hall = hall_s;
    assign dif.cs   = cs;
    assign dif.fwd  = fwd;
    assign dif.four = four;

    // ==========================================
    // sawtooth helpers
    // the ramp counts 0 .. CHOP_CYC-1 and wraps; the
    // wrap stands in for the rising saw edge that
    // re-arms the latched enable, so the drivers
    // re-enable at most once per chopping period
    // last ramp value
    localparam logic [15:0] SAW_LAST = 16'(CHOP_CYC - 1);
    // length of one feedback pulse
    localparam logic [15:0] TACH_LEN = 16'(TACH_CYC);

    logic saw_rise;
    logic chop_on;

    // wrap of the ramp is its rising edge
    assign saw_rise = (st_q.saw == SAW_LAST);
    // duty 0 never on, duty at period or above always on
    assign chop_on  = (st_q.saw < st_q.duty); // RULE19

    // ==========================================
    // feedback level from chosen sensors
    // two or three sensors are exclusive-ORed, so
    // one turn gives two or three falling edges
    // and the speed loop gains as much
    // select 3 falls back to sensor one alone
    function automatic logic bcs_fb(input logic [2:0] h, input logic [1:0] sel);
        logic f;
        case (sel)
            2'h1:    f = h[0] ^ h[1];
            2'h2:    f = h[0] ^ h[1] ^ h[2];
            default: f = h[0];
        endcase
        return f;
    endfunction

    logic fb_now;

    assign fb_now = bcs_fb(hall_s, tsel); // RULE15

    // ==========================================
    // status word
    // read only snapshot of the synced pins, the
    // enable flip-flop and the registered drive;
    // writes to it are ignored
    function automatic logic [15:0] bcs_status(input bcs_state_t s);
        logic [15:0] w;
        w = 16'h0000;
        w[bcs_pkg::STAT_HALL +: 3] = s.s2[2:0];
        w[bcs_pkg::STAT_OC]        = s.s2[3];
        w[bcs_pkg::STAT_BRK]       = s.s2[4];
        w[bcs_pkg::STAT_EN]        = s.en;
        w[bcs_pkg::STAT_DRV +: 6]  = s.drv;
        return w;
    endfunction

    // ==========================================
    // next state
    always_comb
    begin
        st_d = st_q;

        // two stages for every motor pin input
        st_d.s1 = {brake_in, overcurrent_in, hall_in}; // RULE17
        st_d.s2 = st_q.s1;                             // RULE17

        // sawtooth oscillator
        if (saw_rise)
        begin
            st_d.saw = 16'h0000;
        end
        else
        begin
            st_d.saw = st_q.saw + 16'h0001;
        end

        // enable flip-flop of the latched mode
        // the trip wins over the saw edge: the flip-flop
        // may not set again while overcurrent stands
        if (oc_s)
        begin
            st_d.en = 1'b0; // RULE1
        end
        else if (saw_rise)
        begin
            st_d.en = 1'b1; // RULE2
        end

        // output selection, brake first
        // brake shorts the windings even with run clear;
        // overcurrent forces the off pattern in both modes
        if (brk_s)
        begin
            st_d.drv = bcs_pkg::DRV_BRAKE; // RULE5 RULE6
        end
        else if (oc_s)
        begin
            st_d.drv = bcs_pkg::DRV_OFF;   // RULE3 RULE4
        end
        else if (latch && !st_q.en)
        begin
            st_d.drv = bcs_pkg::DRV_OFF;   // RULE1
        end
        else if (!run || !chop_on)
        begin
            st_d.drv = bcs_pkg::DRV_OFF;   // RULE19
        end
        else
        begin
            st_d.drv = dif.pattern;
        end

        // fixed width feedback pulse on falling edge
        // a new falling edge restarts the timer, so edges
        // closer than TACH_CYC merge into one pulse
        st_d.fb_q = fb_now;
        if (st_q.fb_q && !fb_now)
        begin
            st_d.tach   = TACH_LEN;        // RULE16
            st_d.tpulse = 1'b1;
        end
        else if (st_q.tach > 16'h0001)
        begin
            st_d.tach   = st_q.tach - 16'h0001;
            st_d.tpulse = 1'b1;
        end
        else
        begin
            st_d.tach   = 16'h0000;
            st_d.tpulse = 1'b0;
        end

        // register writes
        // status and unmapped indexes ignore writes
        if (reg_wr_in)
        begin
            case (reg_addr_in)
                bcs_pkg::REG_CTRL: st_d.ctrl = reg_wdata_in[7:0];
                bcs_pkg::REG_DUTY: st_d.duty = reg_wdata_in;
                default:           st_d.ctrl = st_q.ctrl;
            endcase
        end

        // read data only in the cycle after the strobe
        // and zero in every other cycle
        st_d.rdata = 16'h0000;
        if (reg_rd_in)
        begin
            case (reg_addr_in)
                bcs_pkg::REG_CTRL:   st_d.rdata = {8'h00, st_q.ctrl};
                bcs_pkg::REG_DUTY:   st_d.rdata = st_q.duty;
                bcs_pkg::REG_STATUS: st_d.rdata = bcs_status(st_q);
                default:             st_d.rdata = 16'h0000;
            endcase
        end
    end

    // ==========================================
    // state register
    // the enable flip-flop starts clear, so drive
    // in latched mode waits for the first saw wrap after reset
    // reset is synchronous and loads constants only
    always_ff @(posedge clk_sys_in)
    begin
        if (!rst_n_in)
        begin
            st_q.s1     <= 5'h00;
            st_q.s2     <= 5'h00;
            st_q.fb_q   <= 1'b0;
            st_q.tach   <= 16'h0000;
            st_q.tpulse <= 1'b0;
            st_q.ctrl   <= bcs_pkg::CTRL_RESET;
            st_q.duty   <= bcs_pkg::DUTY_RESET;
            st_q.saw    <= 16'h0000;
            st_q.en     <= 1'b0;
            st_q.drv    <= bcs_pkg::DRV_OFF;
            st_q.rdata  <= 16'h0000;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    // ==========================================
    // outputs straight from flip-flops
    // no logic stands between st_q and the pins
    assign drv_out        = st_q.drv;
    assign tach_pulse_out = st_q.tpulse;
    assign reg_rdata_out  = st_q.rdata;

endmodule

//--- tb/bcs_motor.sv
// Purpose: hall sensors and driver bridge seen by the sequencer
// Assumes: rotor step chosen by the bench
// Notes:   hall bit0 is sensor one
`timescale 1ns/1ps
module bcs_motor
(
    // rotor and drive
    input  wire logic [2:0] pos_in,
    input  wire logic       wide_in,
    input  wire logic       four_in,
    input  wire logic [5:0] drv_in,
    // sensors and coil check
    output logic      [2:0] hall_out,
    output logic            coil_err_out
);
    // ==========
    // sensor codes per rotor step, narrow, wide and quarter spacing
    localparam logic [2:0] S60 [6]  = '{3'h1, 3'h3, 3'h7, 3'h6, 3'h4, 3'h0};
    localparam logic [2:0] S120 [6] = '{3'h1, 3'h3, 3'h2, 3'h6, 3'h4, 3'h5};
    localparam logic [1:0] S90 [4]  = '{2'h0, 2'h1, 2'h3, 2'h2};
    // two sensors, third input strapped to the second
    assign hall_out = four_in ? {S90[pos_in[1:0]][1], S90[pos_in[1:0]]}
                    : (wide_in ? S120[pos_in] : S60[pos_in]);
    // centre tapped coils hang only on outputs 1, 3, 4 and 6
    assign coil_err_out = four_in && (!drv_in[1] || drv_in[4]);
endmodule

//--- tb/bcs_sequencer_props.sv
// Purpose: timing checks on the sequencer pins
// Assumes: pin inputs pass two sync stages
// Notes:   bound into every sequencer
`timescale 1ns/1ps
module bcs_sequencer_props
#(
    parameter int unsigned CHOP_CYC = bcs_pkg::CHOP_CYC,
    parameter int unsigned TACH_CYC = bcs_pkg::TACH_CYC
)
(
    // clock and reset
    input wire logic        clk_sys_in,
    input wire logic        rst_n_in,
    // watched pins
    input wire logic        reg_rd_in,
    input wire logic [15:0] reg_rdata_out,
    input wire logic        overcurrent_in,
    input wire logic        brake_in,
    input wire logic [5:0]  drv_out,
    input wire logic        tach_pulse_out
);
    // ==========
    // checks
    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (!rst_n_in);
    int unsigned hi_q;
    // length of the running feedback pulse
    always_ff @(posedge clk_sys_in)
    begin
        hi_q <= tach_pulse_out ? hi_q + 1 : 0;
    end
    a_brake_drive: assert property (brake_in [*3] |=> drv_out == 6'h3f)
        else $error("brake pattern missing");
    a_brake_wins: assert property ((brake_in && overcurrent_in) [*3] |=> drv_out == 6'h3f)
        else $error("overcurrent beat brake");
    a_oc_off: assert property ((overcurrent_in && !brake_in) [*3] |=> drv_out == 6'h07)
        else $error("drivers on in overcurrent");
    a_one_pair: assert property (drv_out != 6'h3f |->
        $countones(~drv_out[2:0]) <= 1 && $countones(drv_out[5:3]) <= 1)
        else $error("more than one output per leg");
    a_brake_sync: assert property ((!brake_in) [*3] ##1 brake_in |-> ##2 drv_out != 6'h3f)
        else $error("brake used before sync");
    a_brake_gone: assert property ((!brake_in) [*3] |=> drv_out != 6'h3f)
        else $error("brake pattern without brake");
    a_tach_width: assert property ($fell(tach_pulse_out) |-> hi_q >= TACH_CYC)
        else $error("feedback pulse too short");
    a_rd_idle: assert property (!$past(reg_rd_in) |-> reg_rdata_out == 16'h0000)
        else $error("read data outside its cycle");
endmodule
bind bcs_sequencer bcs_sequencer_props #(.CHOP_CYC(CHOP_CYC), .TACH_CYC(TACH_CYC))
    bcs_sequencer_props_inst (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
    .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .overcurrent_in(overcurrent_in),
    .brake_in(brake_in), .drv_out(drv_out), .tach_pulse_out(tach_pulse_out));

//--- tb/tb_bcs_sequencer.sv
// Purpose: self checking bench for the commutation sequencer
// Assumes: chop period 8 cycles, feedback pulse 3 cycles
// Notes:   random draws from a fixed xorshift seed
`timescale 1ns/1ps
module tb_bcs_sequencer;
    localparam int CC = 8;
    localparam int DUTY [3] = '{0, 3, 8};
    localparam int SNK [6] = '{2, 2, 1, 1, 0, 0};
    localparam int SRC [6] = '{4, 3, 3, 5, 5, 4};
    localparam int QB [4] = '{0, 2, 3, 5};
    logic clk_sys = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, oc = 1'b0, brk = 1'b0;
    logic wide = 1'b0, four = 1'b0, tach, cerr;
    logic [3:0] addr = 4'h0;
    logic [15:0] wdata = 16'h0000, rdata;
    logic [2:0] pos = 3'h0, hall;
    logic [5:0] drv;
    logic [31:0] r;
    logic [1:0] cs;
    int err_count = 0, samples_checked = 0, tc = 0, n, mx;
    int unsigned seed = 32'hc04f_8379;

    // ==========
    // clock, models and design
    always #50 clk_sys = ~clk_sys;
    always @(posedge tach) tc++;
    bcs_motor bcs_motor_inst (.pos_in(pos), .wide_in(wide), .four_in(four), .drv_in(drv),
        .hall_out(hall), .coil_err_out(cerr));
    bcs_sequencer #(.CHOP_CYC(CC), .TACH_CYC(3)) bcs_sequencer_inst (.clk_sys_in(clk_sys),
        .rst_n_in(rst_n), .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr),
        .reg_rd_in(rd), .reg_rdata_out(rdata), .hall_in(hall), .overcurrent_in(oc),
        .brake_in(brk), .drv_out(drv), .tach_pulse_out(tach));

    // ==========
    // helpers
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // expected drive for a rotor step, direction and phase count
    function automatic logic [5:0] drv_exp(int p, logic f, logic fr);
        logic [5:0] v;
        int k;
        v = 6'h07;
        k = f ? p : (p + (fr ? 2 : 3)) % (fr ? 4 : 6);
        if (fr)
            v[QB[k]] = (QB[k] > 2);
        else
        begin
            v[SNK[k]] = 1'b0;
            v[SRC[k]] = 1'b1;
        end
        return v;
    endfunction
    task automatic chk(logic [15:0] got, logic [15:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            err_count++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr_reg(logic [3:0] a, logic [15:0] d);
        @(posedge clk_sys);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk_sys);
        wr <= 1'b0;
    endtask
    task automatic rd_chk(logic [3:0] a, logic [15:0] exp);
        @(posedge clk_sys);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk_sys);
        rd <= 1'b0;
        #1;
        chk(rdata, exp);
    endtask
    task automatic step(logic [2:0] p);
        @(posedge clk_sys);
        pos <= p;
        repeat (6) @(posedge clk_sys);
        #1;
    endtask
    task automatic conclude();
        $display("compared %0d mismatched %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // ==========
    // watchdog
    initial
    begin
        #800000;
        err_count++;
        conclude();
    end

    // ==========
    // main sequence
    initial
    begin
        repeat (10) @(posedge clk_sys);
        rst_n <= 1'b1;
        rd_chk(4'h0, 16'h0002);
        rd_chk(4'h1, 16'h0000);
        rd_chk(4'hf, 16'h0000);
        wr_reg(4'h1, 16'h00ff);
        wr_reg(4'h0, 16'h0003);
        for (int t = 0; t < 12; t++)
        begin
            step(t % 6);
            chk(16'(drv), 16'(drv_exp(t % 6, 1'b1, 1'b0)));
        end
        step(0);
        chk(16'(drv), 16'h0013);
        step(1);
        chk(16'(drv), 16'h000b);
        $display("test commutation walk done");
        // random direction, spacing and phase count
        for (int i = 0; i < 60; i++)
        begin
            r = rnd();
            cs = r[3:2] & {2{~r[0]}};
            wr_reg(4'h0, {10'h000, r[0], 1'b0, cs, r[1], 1'b1});
            four <= r[0];
            wide <= cs[0] ^ cs[1];
            n = r[0] ? r[5:4] : r[6:4] % 6;
            step(n[2:0]);
            if (cs[1])
                chk(16'(drv), 16'(drv_exp(5 - n, r[1], 1'b0)));
            else
                chk(16'(drv), 16'(drv_exp(n, r[1], r[0])));
            chk(16'(cerr), 16'h0000);
        end
        wr_reg(4'h0, 16'h0003);
        four <= 1'b0;
        wide <= 1'b0;
        step(0);
        $display("test random decode done");
        for (int d = 0; d < 3; d++)
        begin
            wr_reg(4'h1, 16'(DUTY[d]));
            repeat (3) @(posedge clk_sys);
            n = 0;
            repeat (32)
            begin
                @(posedge clk_sys);
                #1;
                n += (drv === 6'h13);
            end
            chk(16'(n), 16'(4 * DUTY[d]));
        end
        rd_chk(4'h2, 16'h04e1);
        $display("test chopping done");
        for (int m = 0; m < 2; m++)
        begin
            wr_reg(4'h0, 16'h0003 | 16'(m << 4));
            mx = 0;
            for (int k = 0; k < 8; k++)
            begin
                repeat (k + 12) @(posedge clk_sys);
                oc <= 1'b1;
                repeat (5) @(posedge clk_sys);
                #1;
                chk(16'(drv), 16'h0007);
                @(posedge clk_sys);
                oc <= 1'b0;
                n = 0;
                do
                begin
                    @(posedge clk_sys);
                    #1;
                    n++;
                end
                while (drv !== 6'h13 && n < 30);
                mx = (n > mx) ? n : mx;
                chk(16'(n <= (m ? CC + 6 : 4)), 16'h0001);
            end
            chk(16'(mx > 4 || m == 0), 16'h0001);
        end
        $display("test overcurrent done");
        @(posedge clk_sys);
        brk <= 1'b1;
        oc <= 1'b1;
        repeat (5) @(posedge clk_sys);
        #1;
        chk(16'(drv), 16'h003f);
        wr_reg(4'h0, 16'h0002);
        oc <= 1'b0;
        repeat (5) @(posedge clk_sys);
        #1;
        chk(16'(drv), 16'h003f);
        @(posedge clk_sys);
        brk <= 1'b0;
        $display("test brake done");
        for (int s = 0; s < 4; s++)
        begin
            wr_reg(4'h0, 16'h0003 | 16'(s << 6));
            step(5);
            tc = 0;
            for (int t = 0; t < 6; t++)
                step(t);
            chk(16'(tc), 16'(s % 3 + 1));
        end
        $display("test feedback done");
        conclude();
    end
endmodule
